/* File: hw/spvp_defs.vh */
// Constants of the serial program/verify port
`ifndef SPVP_DEFS_VH
`define SPVP_DEFS_VH
`define SPVP_CMD_BITS 6
`define SPVP_DATA_CYCLES 16
`define SPVP_WORD_BITS 14
`define SPVP_ADDR_BITS 14
`define SPVP_CMD_LOAD_CFG 4'h0
`define SPVP_CMD_LOAD_PGM 4'h2
`define SPVP_CMD_READ_PGM 4'h4
`define SPVP_CMD_INC_ADDR 4'h6
`define SPVP_CMD_LOAD_DAT 4'h3
`define SPVP_CMD_READ_DAT 4'h5
`define SPVP_CMD_BULK_PGM 4'h9
`define SPVP_CMD_BULK_DAT 4'hb
`define SPVP_CMD_ERASE_PROG 6'h08
`define SPVP_CMD_PROG_ONLY 6'h18
`define SPVP_CFG_BASE 14'h2000
`define SPVP_USER_TOP 14'h1fff
`define SPVP_TEST_TOP 14'h200f
`define SPVP_CFG_WORD 14'h2007
`define SPVP_ALL_ONES 14'h3fff
`define SPVP_PROG_TIME_NS 10000000
`define SPVP_CLK_NS 20
`endif

/* File: hw/spvp_buf2.v */
// Two-entry valid/ready buffer
module spvp_buf2 (
   input wire clk_sys,
   input wire srst,
   input wire [13:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [13:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [13:0] mem_q [0:1];
   reg rd_q;
   reg wr_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge clk_sys) begin
      if (srst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'd0;
         mem_q[0] <= 14'h0000;
         mem_q[1] <= 14'h0000;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'd1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'd1;
      end
   end
endmodule // spvp_buf2

/* File: hw/spvp_port.v */
// Serial program/verify port: command decoder, address counter, memories
// What this block does
// R1: Programmer holds clock/data low entering high voltage
// R2: Low-voltage entry pin works when enabled
// R3: Entry resets other logic, pins tri-stated
// R4: Reset clears address counter to zero
// R5: Six-bit command, falling-edge latch, LSB first
// R6: Programmer leaves 1 us gaps
// R7: Data phase: start, fourteen bits, stop
// R8: Read drives pin rising edges two to sixteen
// R9: Load latches bits from second falling edge
// R10: Decode load config, load program, read program
// R11: Decode increment, load data, read data
// R12: Full six bits for begin programming commands
// R13: Bulk erase codes, no data phase
// R14: Load config jumps counter to configuration space
// R15: Increment command adds one to counter
// R16: Data memory uses low eight data bits
// R17: Data memory 64 bytes, address wraps
// R18: Load precedes programming; internal write timing
// R19: Programming-only writes without word erase; data memory writes overwrite the byte for both commands
// R20: Bulk erase armed, executed by next program
// R21: Test-region bulk erase clears test, keeps config
// R22: Code protection blocks bulk erase
// R23: Counter wraps within user or configuration space
// R24: Unknown commands ignored, no data phase
`include "spvp_defs.vh"
module spvp_port #(
   parameter PROG_TIME_NS = `SPVP_PROG_TIME_NS
) (
   input wire clk_sys,
   input wire srst,
   input wire master_clear_pin,
   input wire high_entry_voltage,
   input wire low_voltage_entry_pin,
   input wire low_voltage_entry_enable,
   input wire code_protect,
   input wire serial_clock_pin,
   input wire serial_data_pin_i,
   output reg serial_data_pin_o,
   output reg serial_data_pin_oe,
   output wire prog_mode,
   output wire prog_busy,
   output reg [13:0] addr_q,
   output wire [13:0] load_word,
   output wire load_valid,
   input wire load_ready
);
   localparam [23:0] PROG_CYCLES = PROG_TIME_NS / `SPVP_CLK_NS;
   localparam [2:0] ST_CMD = 3'd0;
   localparam [2:0] ST_LOAD = 3'd1;
   localparam [2:0] ST_READ = 3'd2;
   localparam [2:0] ST_IDLE = 3'd3;
   localparam [1:0] MEM_PGM = 2'd0;
   localparam [1:0] MEM_DAT = 2'd1;
   localparam [1:0] MEM_CFG = 2'd2;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [1:0] master_clear_pin_s;
   reg [1:0] hv_s;
   reg [1:0] lvp_s;
   reg [1:0] clk_s;
   reg [1:0] dat_s;
   reg clk_d1_q;
   always @(posedge clk_sys) begin
      if (srst) begin
         master_clear_pin_s <= 2'b00;
         hv_s <= 2'b00;
         lvp_s <= 2'b00;
         clk_s <= 2'b00;
         dat_s <= 2'b00;
         clk_d1_q <= 1'b0;
      end else begin
         master_clear_pin_s <= {master_clear_pin_s[0], master_clear_pin};
         hv_s <= {hv_s[0], high_entry_voltage};
         lvp_s <= {lvp_s[0], low_voltage_entry_pin};
         clk_s <= {clk_s[0], serial_clock_pin};
         dat_s <= {dat_s[0], serial_data_pin_i};
         clk_d1_q <= clk_s[1];
      end
   end
   wire sck_rise = clk_s[1] && !clk_d1_q;
   wire sck_fall = !clk_s[1] && clk_d1_q;
   wire sdi = dat_s[1];

   // ----------------------------------------
   // Mode entry
   // ----------------------------------------
   reg mode_q;
   wire want_mode = hv_s[1] || (low_voltage_entry_enable && master_clear_pin_s[1] && lvp_s[1]); // [R2]
   wire enter = want_mode && !mode_q;
   // Clock and data must be low at entry, else entry waits until both are low
   wire pins_low = !clk_s[1] && !sdi; // [R1]
   always @(posedge clk_sys) begin
      if (srst)
         mode_q <= 1'b0;
      else if (!master_clear_pin_s[1] || !want_mode)
         mode_q <= 1'b0;
      else if (enter && pins_low)
         mode_q <= 1'b1;
   end
   assign prog_mode = mode_q; // [R3]

   // ----------------------------------------
   // Memories
   // ----------------------------------------
   reg [13:0] pgm_mem [0:8191];
   reg [13:0] tst_mem [0:15];
   reg [7:0] dat_mem [0:63];

   // ----------------------------------------
   // Serial engine
   // ----------------------------------------
   reg [2:0] st_q;
   reg [4:0] cnt_q;
   reg [5:0] cmd_q;
   reg [15:0] sh_q;
   reg [1:0] ld_mem_q;
   reg [1:0] arm_mem_q;
   reg loaded_q;
   reg bulk_pgm_q;
   reg bulk_dat_q;
   reg cfg_q;
   reg [13:0] word_q;
   reg wr_req_q;
   reg wr_erase_q;
   reg [23:0] busy_q;
   reg [13:0] rd_word;
   wire [5:0] cmd_full = {sdi, cmd_q[5:1]};

   // ----------------------------------------
   // Address helpers
   // ----------------------------------------
   // Test region sits at the bottom of configuration space
   function is_test;
      input [13:0] a;
      begin
         is_test = a[13] && (a <= `SPVP_TEST_TOP);
      end
   endfunction

   // Address advance inside the current space
   function [13:0] next_addr;
      input [13:0] a;
      begin
         if (a == `SPVP_USER_TOP)
            next_addr = 14'h0000; // [R23]
         else if (a == `SPVP_ALL_ONES)
            next_addr = `SPVP_CFG_BASE; // [R23]
         else
            next_addr = a + 14'h0001;
      end
   endfunction

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Word picked once per read, at the second rising edge
   always @* begin
      if (st_q == ST_READ && cmd_q[3:0] == `SPVP_CMD_READ_DAT)
         rd_word = {6'h00, dat_mem[addr_q[5:0]]}; // [R17]
      else if (is_test(addr_q))
         rd_word = tst_mem[addr_q[3:0]];
      else
         rd_word = pgm_mem[addr_q[12:0]];
   end

   // ----------------------------------------
   // Load buffer
   // ----------------------------------------
   // Stalled receiver keeps two words; a third is dropped
   reg buf_v_q;
   wire buf_rdy;
   spvp_buf2 u_buf (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_data(sh_q[14:1]),
      .in_valid(buf_v_q),
      .in_ready(buf_rdy),
      .out_data(load_word),
      .out_valid(load_valid),
      .out_ready(load_ready)
   );
   assign prog_busy = (busy_q != 24'd0);

   // ----------------------------------------
   // Serial state machine and write engine
   // ----------------------------------------
   // Leaving the mode clears the engine registers, as a fresh entry does; memories and load buffer keep their contents
   integer i;
   always @(posedge clk_sys) begin
      buf_v_q <= 1'b0;
      if (srst || !mode_q) begin
         st_q <= ST_CMD;
         cnt_q <= 5'd0;
         cmd_q <= 6'h00;
         sh_q <= 16'h0000;
         addr_q <= 14'h0000; // [R4]
         loaded_q <= 1'b0;
         ld_mem_q <= MEM_PGM;
         arm_mem_q <= MEM_PGM;
         bulk_pgm_q <= 1'b0;
         bulk_dat_q <= 1'b0;
         cfg_q <= 1'b0;
         word_q <= 14'h0000;
         wr_req_q <= 1'b0;
         wr_erase_q <= 1'b0;
         busy_q <= 24'd0;
         serial_data_pin_o <= 1'b0;
         serial_data_pin_oe <= 1'b0; // [R3]
      end else begin
         if (busy_q != 24'd0)
            busy_q <= busy_q - 24'd1; // [R18]
         case (st_q)
            ST_CMD: begin
               if (sck_fall) begin
                  cmd_q <= cmd_full; // [R5]
                  if (cnt_q == 5'd5) begin
                     cnt_q <= 5'd0;
                     st_q <= ST_CMD;
                     case (cmd_full[3:0])
                        `SPVP_CMD_LOAD_CFG: begin
                           addr_q <= `SPVP_CFG_BASE; // [R14]
                           cfg_q <= 1'b1;
                           ld_mem_q <= MEM_CFG;
                           st_q <= ST_LOAD; // [R10]
                        end
                        `SPVP_CMD_LOAD_PGM: begin
                           ld_mem_q <= MEM_PGM;
                           st_q <= ST_LOAD; // [R10]
                        end
                        `SPVP_CMD_LOAD_DAT: begin
                           ld_mem_q <= MEM_DAT;
                           st_q <= ST_LOAD; // [R11]
                        end
                        `SPVP_CMD_READ_PGM, `SPVP_CMD_READ_DAT: st_q <= ST_READ; // [R10] [R11]
                        `SPVP_CMD_INC_ADDR: addr_q <= next_addr(addr_q); // [R15] [R11]
                        `SPVP_CMD_BULK_PGM: bulk_pgm_q <= !code_protect; // [R13] [R22]
                        `SPVP_CMD_BULK_DAT: bulk_dat_q <= !code_protect; // [R13] [R22]
                        default: begin
                           // Programming commands need all six bits
                           if ((cmd_full == `SPVP_CMD_ERASE_PROG ||
                                cmd_full == `SPVP_CMD_PROG_ONLY) && loaded_q) begin // [R12] [R18]
                              wr_req_q <= 1'b1;
                              wr_erase_q <= (cmd_full == `SPVP_CMD_ERASE_PROG); // [R19]
                              arm_mem_q <= ld_mem_q;
                              loaded_q <= 1'b0;
                              busy_q <= PROG_CYCLES;
                           end
                           // Others fall through with no effect [R24]
                        end
                     endcase
                  end else begin
                     cnt_q <= cnt_q + 5'd1;
                  end
               end
            end
            ST_LOAD: begin
               if (sck_fall) begin
                  sh_q <= {sdi, sh_q[15:1]}; // [R9] [R7]
                  if (cnt_q == 5'd15) begin
                     cnt_q <= 5'd0;
                     st_q <= ST_CMD;
                     // Start bit in sh_q[1], stop bit not yet shifted
                     word_q <= sh_q[15:2];
                     loaded_q <= 1'b1;
                     buf_v_q <= buf_rdy;
                  end else begin
                     cnt_q <= cnt_q + 5'd1;
                  end
               end
            end
            ST_READ: begin
               if (sck_rise) begin
                  // Drive from the second rising edge through the sixteenth [R8]
                  if (cnt_q == 5'd1) begin
                     serial_data_pin_oe <= 1'b1;
                     sh_q <= {2'b00, rd_word};
                     serial_data_pin_o <= rd_word[0];
                  end else if (cnt_q == 5'd15) begin
                     serial_data_pin_oe <= 1'b0;
                     serial_data_pin_o <= 1'b0;
                  end else if (cnt_q > 5'd1) begin
                     sh_q <= {1'b0, sh_q[15:1]};
                     serial_data_pin_o <= sh_q[1];
                  end
                  // Sixteen clocks always run for data memory too [R16]
                  cnt_q <= cnt_q + 5'd1;
               end
               // Wait for the last falling edge, else it counts as a command bit
               if (sck_fall && cnt_q == 5'd16) begin
                  cnt_q <= 5'd0;
                  st_q <= ST_CMD;
               end
            end
            default: st_q <= ST_CMD;
         endcase

         // Write at programming, after decode; one per load
         if (wr_req_q) begin
            wr_req_q <= 1'b0;
            if (arm_mem_q == MEM_DAT) begin
               if (bulk_dat_q) begin
                  for (i = 0; i < 64; i = i + 1)
                     dat_mem[i] <= 8'hff;
                  bulk_dat_q <= 1'b0;
               end else
                  dat_mem[addr_q[5:0]] <= word_q[7:0]; // [R16] [R17]
            end else if (bulk_pgm_q) begin
               // Whole array cleared by the next program command not aimed at data memory [R20]
               for (i = 0; i < 8192; i = i + 1)
                  pgm_mem[i] <= `SPVP_ALL_ONES;
               if (is_test(addr_q)) begin
                  for (i = 0; i < 16; i = i + 1)
                     if (i != 7)
                        tst_mem[i] <= `SPVP_ALL_ONES; // [R21]
               end
               bulk_pgm_q <= 1'b0;
            end else if (is_test(addr_q)) begin
               tst_mem[addr_q[3:0]] <= wr_erase_q ? word_q :
                                       (tst_mem[addr_q[3:0]] & word_q); // [R19]
            end else begin
               pgm_mem[addr_q[12:0]] <= wr_erase_q ? word_q :
                                        (pgm_mem[addr_q[12:0]] & word_q); // [R19]
            end
         end
      end
   end
endmodule // spvp_port

/* File: verif/spvp_prog_model.sv */
// Programmer model driving the serial clock and data pins
module spvp_prog_model (
   output logic sclk,
   output logic sdat,
   output logic sdat_en,
   input wire logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // Frames
   // ------
   initial begin
      sclk = 1'b0;
      sdat = 1'b0;
      sdat_en = 1'b1;
   end
   // Set on rising, latched on falling; pin released for reads
   task automatic xfer(input int n, input logic [15:0] bits, input logic rd,
                       output logic [13:0] got);
      got = 14'h0;
      // Drift keeps link edges off the system clock phase
      #3;
      for (int i = 0; i < n; i++) begin
         if (rd && i > 1) got[i-2] = pin;
         sclk = 1'b1;
         sdat_en = !rd;
         sdat = bits[i];
         #80;
         sclk = 1'b0;
         #80;
      end
      #1000;
      sdat_en = 1'b1;
      sdat = 1'b0;
   endtask
endmodule // spvp_prog_model

/* File: verif/spvp_port_asserts.sv */
// Concurrent checks on the serial program/verify port
module spvp_port_asserts (
   input logic clk_sys,
   input logic srst,
   input logic master_clear_pin,
   input logic high_entry_voltage,
   input logic low_voltage_entry_enable,
   input logic serial_clock_pin,
   input logic serial_data_pin_oe,
   input logic prog_mode,
   input logic [13:0] addr_q,
   input logic [13:0] load_word,
   input logic load_valid,
   input logic load_ready
);
   // ------
   // Checks
   // ------
   logic sclk_q;
   logic [3:0] rise_cnt_q;
   default clocking spvp_cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Raw pin: edge 2 lands before the synced drive starts, so 14 remain
   always @(posedge clk_sys) begin
      sclk_q <= serial_clock_pin;
      if (!serial_data_pin_oe) rise_cnt_q <= 4'h0;
      else rise_cnt_q <= rise_cnt_q + {3'h0, serial_clock_pin & !sclk_q};
   end
   mode_drive_a: assert property (serial_data_pin_oe |-> prog_mode)
      else $error("data pin driven outside mode");
   mode_exit_a: assert property (!master_clear_pin [*8] |-> !prog_mode)
      else $error("mode kept after master clear low");
   entry_clean_a: assert property ($rose(prog_mode) |-> addr_q == 14'h0 && !serial_data_pin_oe)
      else $error("entry without cleared counter");
   entry_kind_a: assert property ($rose(prog_mode) |-> high_entry_voltage || low_voltage_entry_enable)
      else $error("low voltage entry while disabled");
   addr_step_a: assert property ($changed(addr_q) && prog_mode && master_clear_pin |->
      addr_q == 14'h2000 || addr_q == ((($past(addr_q) + 14'h1) & 14'h1fff) | ($past(addr_q) & 14'h2000)))
      else $error("address counter step wrong");
   cfg_sticky_a: assert property (prog_mode && $past(prog_mode) && $past(addr_q[13]) |-> addr_q[13])
      else $error("left configuration space");
   drive_edge_a: assert property ($rose(serial_data_pin_oe) |-> serial_clock_pin)
      else $error("drive not started in clock high phase");
   drive_len_a: assert property ($fell(serial_data_pin_oe) |-> serial_clock_pin && rise_cnt_q == 4'he)
      else $error("drive not released after sixteenth rise");
   load_hold_a: assert property (load_valid && !load_ready |=> load_valid && $stable(load_word))
      else $error("buffered word lost in stall");
   cover property ($fell(serial_data_pin_oe));
   cover property ($rose(prog_mode));
   cover property (load_valid && !load_ready);
endmodule // spvp_port_asserts

bind spvp_port spvp_port_asserts spvp_port_asserts_inst (.clk_sys, .srst, .master_clear_pin,
   .high_entry_voltage, .low_voltage_entry_enable, .serial_clock_pin, .serial_data_pin_oe,
   .prog_mode, .addr_q, .load_word, .load_valid, .load_ready);

/* File: verif/spvp_port_tb_top.sv */
// Self-checking bench for the serial program/verify port
module spvp_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int k; logic [5:0] c; logic [13:0] d; logic [13:0] a;} spvp_row_t;
   logic clk_sys = 1'b0, srst = 1'b1, mc = 1'b0, hv = 1'b0, lv = 1'b0, lve = 1'b0;
   logic cp = 1'b0, rdy = 1'b1, prev_q = 1'b0;
   logic sclk, sdat, sdat_en, pin, d_o, d_oe, pmode, busy, lvld;
   logic [13:0] addr, lword, got, rv;
   int failures = 0, n_tests = 0, cyc = 0;
   // Kind: 0 command, 1 load, 2 word read, 3 byte read, 4 program, 5 protect, 6 steps
   spvp_row_t rows[32] = '{
      '{1, 6'h02, 14'h1234, 14'h0}, '{4, 6'h08, 14'h0, 14'h0}, '{2, 6'h34, 14'h1234, 14'h0},
      '{1, 6'h02, 14'h3fff, 14'h0}, '{0, 6'h09, 14'h0, 14'h0}, '{4, 6'h08, 14'h0, 14'h0},
      '{2, 6'h04, 14'h3fff, 14'h0}, '{1, 6'h22, 14'h0abc, 14'h0}, '{4, 6'h18, 14'h0, 14'h0},
      '{2, 6'h04, 14'h0abc, 14'h0}, '{0, 6'h36, 14'h0, 14'h1}, '{0, 6'h0e, 14'h0, 14'h1},
      '{0, 6'h28, 14'h0, 14'h1}, '{1, 6'h13, 14'h3fa5, 14'h1}, '{4, 6'h08, 14'h0, 14'h1},
      '{3, 6'h25, 14'h00a5, 14'h1}, '{5, 6'h0, 14'h1, 14'h1}, '{1, 6'h03, 14'h00a5, 14'h1},
      '{0, 6'h0b, 14'h0, 14'h1}, '{4, 6'h08, 14'h0, 14'h1}, '{5, 6'h0, 14'h0, 14'h1},
      '{3, 6'h05, 14'h00a5, 14'h1}, '{6, 6'h06, 14'h0, 14'h0041},
      '{3, 6'h05, 14'h00a5, 14'h0041}, '{1, 6'h03, 14'h3fff, 14'h0041},
      '{0, 6'h3b, 14'h0, 14'h0041}, '{4, 6'h08, 14'h0, 14'h0041},
      '{3, 6'h05, 14'h00ff, 14'h0041}, '{1, 6'h00, 14'h0155, 14'h2000},
      '{4, 6'h08, 14'h0, 14'h2000}, '{2, 6'h04, 14'h0155, 14'h2000}, '{0, 6'h06, 14'h0, 14'h2001}};
   // ------
   // Harness
   // ------
   always #10 clk_sys = ~clk_sys;
   // Released line shows no stale level
   always @(posedge clk_sys) prev_q <= pin;
   assign pin = d_oe ? d_o : sdat_en ? sdat : ~prev_q;
   spvp_port #(.PROG_TIME_NS(2000)) spvp_port_inst (.clk_sys, .srst, .master_clear_pin(mc),
      .high_entry_voltage(hv), .low_voltage_entry_pin(lv), .low_voltage_entry_enable(lve),
      .code_protect(cp), .serial_clock_pin(sclk), .serial_data_pin_i(pin),
      .serial_data_pin_o(d_o), .serial_data_pin_oe(d_oe), .prog_mode(pmode), .prog_busy(busy),
      .addr_q(addr), .load_word(lword), .load_valid(lvld), .load_ready(rdy));
   spvp_prog_model spvp_prog_model_inst (.sclk, .sdat, .sdat_en, .pin);
   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         stop_test();
      end
   end
   task automatic cmd(input logic [5:0] c);
      spvp_prog_model_inst.xfer(6, {10'h0, c}, 1'b0, got);
   endtask
   task automatic load(input logic [5:0] c, input logic [13:0] w);
      cmd(c);
      spvp_prog_model_inst.xfer(16, {1'b0, w, 1'b0}, 1'b0, got);
   endtask
   task automatic read(input logic [5:0] c, output logic [13:0] w);
      cmd(c);
      spvp_prog_model_inst.xfer(16, 16'h0, 1'b1, w);
   endtask
   // Waits out the internal timer before the next command
   task automatic prog(input logic [5:0] c);
      cmd(c);
      check({13'h0, busy}, 14'h1);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_sys);
   endtask
   task automatic enter(input logic h, input logic e);
      @(posedge clk_sys) begin
         mc <= 1'b1;
         hv <= h;
         lve <= e;
      end
      @(posedge clk_sys) lv <= !h;
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic leave;
      @(posedge clk_sys) begin
         mc <= 1'b0;
         hv <= 1'b0;
         lv <= 1'b0;
      end
      repeat (10) @(posedge clk_sys);
   endtask
   // ------
   // Sequence
   // ------
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      enter(1'b1, 1'b0);
      check({13'h0, pmode}, 14'h1);
      check(addr, 14'h0);
      foreach (rows[i]) begin
         case (rows[i].k)
            0: cmd(rows[i].c);
            1: load(rows[i].c, rows[i].d);
            4: prog(rows[i].c);
            5: @(posedge clk_sys) cp <= rows[i].d[0];
            6: repeat (64) cmd(rows[i].c);
            default: begin
               read(rows[i].c, rv);
               check(rv & (rows[i].k == 2 ? 14'h3fff : 14'h00ff), rows[i].d);
            end
         endcase
         check(addr, rows[i].a);
      end
      leave();
      check({13'h0, pmode}, 14'h0);
      check(addr, 14'h0);
      enter(1'b0, 1'b0);
      check({13'h0, pmode}, 14'h0);
      leave();
      enter(1'b0, 1'b1);
      check({13'h0, pmode}, 14'h1);
      // Full buffer drops the newest word
      @(posedge clk_sys) rdy <= 1'b0;
      load(6'h02, 14'h0111);
      load(6'h02, 14'h0222);
      load(6'h02, 14'h0333);
      check(lword, 14'h0111);
      @(posedge clk_sys) rdy <= 1'b1;
      @(posedge clk_sys) rdy <= 1'b0;
      #1 check(lword, 14'h0222);
      @(posedge clk_sys) rdy <= 1'b1;
      @(posedge clk_sys) rdy <= 1'b0;
      #1 check({13'h0, lvld}, 14'h0);
      stop_test();
   end
endmodule // spvp_port_tb_top
